// file: hw/pstc_seq_cfg.sv
// Contract
// - Gap after strobes 1..8 picked by low register bit n-1: 2 ms or 5 ms.
// - Gap between strobes 9 and 10 picked by high register bit 0.
// - Factor bit set: every gap is ten times longer while sequencing down.
// - Factor never affects power-up gaps.
// - Slot codes 3h..Ah enable buck rail two at strobes 3..10.
// - Slot codes 0h..2h and Bh..Fh leave buck rail two uncontrolled.
// - Slot register resets to 98h.
// - Gap registers reset to zero; high register bits 6..1 read zero.
`timescale 1ns/10ps
module pstc_seq_cfg
    import pstc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR  = 7'h5A, // Arbitrary bus address
    parameter int         SHORT_CYC = GAP_SHORT_CYC,
    parameter int         LONG_CYC  = GAP_LONG_CYC
) (
    // Clock, reset, enable
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    // Serial register port
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    // Sequence requests
    input  wire logic       pwr_up_req_in,
    input  wire logic       pwr_dn_req_in,
    // Sequencer outputs
    output logic [9:0]      strobe_out,
    output logic            buck_rail_two_en_out,
    output logic            buck_two_managed_out,
    output logic            seq_on_out
);

    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC ||
        longint'(LONG_CYC) * DOWN_FACTOR > 64'h00000000FFFFFFFF)
    begin : g_chk
        $error("pstc_seq_cfg: gap lengths out of range");
    end

    // Pin synchronisers; stage 0 feeds stage 1 only
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
        end else if (ce_in) begin
            scl_s_r <= {scl_s_r[1:0], scl_in};
            sda_s_r <= {sda_s_r[1:0], sda_in};
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop, sda_bit;
    assign sda_bit   = sda_s_r[1];
    assign scl_rise  = scl_s_r[1] & ~scl_s_r[2];
    assign scl_fall  = ~scl_s_r[1] & scl_s_r[2];
    assign bus_start = scl_s_r[1] & scl_s_r[2] & sda_s_r[2] & ~sda_s_r[1];
    assign bus_stop  = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[2] & sda_s_r[1];

    // Serial slave and register file
    pstc_i2c_st_t ist_r, ist_nxt;
    logic [3:0]   bits_r, bits_nxt;
    logic [7:0]   sh_r, sh_nxt;
    logic [7:0]   ptr_r, ptr_nxt;
    logic         rw_r, rw_nxt;
    logic         drv_r, drv_nxt;
    logic         unlock_r, unlock_nxt;
    pstc_regs_t   regs_r, regs_nxt;
    logic [7:0]   rd_data;
    logic         wr_stb;

    always_comb begin
        case (ptr_r)
            GAP_LOW_OFF:  rd_data = regs_r.gap_low;
            GAP_HIGH_OFF: rd_data = regs_r.gap_high;
            SLOT_OFF:     rd_data = regs_r.slot;
            UNLOCK_OFF:   rd_data = {7'h00, unlock_r};
            default:      rd_data = 8'h00;
        endcase
    end

    always_comb begin
        ist_nxt    = ist_r;
        bits_nxt   = bits_r;
        sh_nxt     = sh_r;
        ptr_nxt    = ptr_r;
        rw_nxt     = rw_r;
        drv_nxt    = drv_r;
        unlock_nxt = unlock_r;
        regs_nxt   = regs_r;
        wr_stb     = 1'b0;
        if (bus_start) begin
            ist_nxt  = I_ADDR;
            bits_nxt = 4'h0;
            drv_nxt  = 1'b0;
        end else if (bus_stop) begin
            ist_nxt = I_IDLE;
            drv_nxt = 1'b0;
        end else begin
            case (ist_r)
                I_IDLE: ;
                I_ADDR, I_PTR, I_WDATA: begin
                    if (scl_rise) begin
                        sh_nxt   = {sh_r[6:0], sda_bit};
                        bits_nxt = bits_r + 4'h1;
                    end else if (scl_fall && bits_r == BYTE_BITS) begin
                        bits_nxt = 4'h0;
                        drv_nxt  = 1'b1;
                        ist_nxt  = I_ACK_W;
                        if (ist_r == I_ADDR) begin
                            rw_nxt  = sh_r[0];
                            ist_nxt = I_ACK_A;
                            if (sh_r[7:1] != DEV_ADDR) begin
                                drv_nxt = 1'b0;
                                ist_nxt = I_IDLE;
                            end
                        end else if (ist_r == I_PTR) begin
                            ptr_nxt = sh_r;
                        end else begin
                            wr_stb     = 1'b1;
                            ptr_nxt    = ptr_r + 8'h01;
                            unlock_nxt = 1'b0;
                            case (ptr_r)
                                UNLOCK_OFF:
                                    unlock_nxt = (sh_r == UNLOCK_KEY);
                                GAP_LOW_OFF:
                                    if (unlock_r) regs_nxt.gap_low = sh_r;
                                GAP_HIGH_OFF:
                                    if (unlock_r) regs_nxt.gap_high =
                                        {sh_r[FACTOR_BIT], 6'h00, sh_r[GAP9_BIT]};
                                SLOT_OFF:
                                    if (unlock_r) regs_nxt.slot = sh_r;
                                default: ;
                            endcase
                        end
                    end
                end
                I_ACK_A: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            sh_nxt   = rd_data;
                            drv_nxt  = ~rd_data[7];
                            bits_nxt = 4'h1;
                            ist_nxt  = I_RACK;
                        end else begin
                            drv_nxt = 1'b0;
                            ist_nxt = I_PTR;
                        end
                    end
                end
                I_ACK_W: begin
                    if (scl_fall) begin
                        drv_nxt = 1'b0;
                        ist_nxt = I_WDATA;
                    end
                end
                I_RACK: begin
                    // Shifts out a read byte, then samples the master's ack
                    if (scl_fall && bits_r != 4'h0) begin
                        if (bits_r == BYTE_BITS) begin
                            drv_nxt  = 1'b0;
                            bits_nxt = 4'h0;
                            ptr_nxt  = ptr_r + 8'h01;
                        end else begin
                            drv_nxt  = ~sh_r[6];
                            sh_nxt   = {sh_r[6:0], 1'b0};
                            bits_nxt = bits_r + 4'h1;
                        end
                    end else if (scl_rise && bits_r == 4'h0) begin
                        ist_nxt = sda_bit ? I_IDLE : I_ACK_A;
                    end
                end
                default: ist_nxt = I_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ist_r      <= I_IDLE;
            bits_r     <= 4'h0;
            sh_r       <= 8'h00;
            ptr_r      <= 8'h00;
            rw_r       <= 1'b0;
            drv_r      <= 1'b0;
            unlock_r   <= 1'b0;
            regs_r     <= '{GAP_LOW_RST, GAP_HIGH_RST, SLOT_RST};
            sda_out    <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (ce_in) begin
            ist_r      <= ist_nxt;
            bits_r     <= bits_nxt;
            sh_r       <= sh_nxt;
            ptr_r      <= ptr_nxt;
            rw_r       <= rw_nxt;
            drv_r      <= drv_nxt;
            unlock_r   <= unlock_nxt;
            regs_r     <= regs_nxt;
            sda_out    <= 1'b0;
            sda_oe_out <= drv_nxt;
        end
    end

    // Sequencer
    pstc_seq_st_t sst_r, sst_nxt;
    logic [3:0]   idx_r, idx_nxt;
    logic [9:0]   strobe_nxt;
    logic         en_nxt, on_nxt, tmr_start, tmr_done;
    logic [31:0]  gap_base, gap_load;
    logic [8:0]   gap_bits;
    logic [3:0]   slot;
    logic         slot_ok, factor, gap_sel;

    assign gap_bits = {regs_r.gap_high[GAP9_BIT], regs_r.gap_low};
    assign slot     = regs_r.slot[SLOT_MSB:SLOT_LSB];
    assign slot_ok  = slot >= SLOT_FIRST && slot <= SLOT_LAST;
    assign factor   = regs_r.gap_high[FACTOR_BIT];

    always_comb begin
        // Gap k sits between strobes k and k+1; down counts from the top
        if (sst_r == S_STB_DN)
            gap_sel = gap_bits[idx_r - 4'h2];
        else
            gap_sel = gap_bits[idx_r - 4'h1];
        gap_base = gap_sel ? 32'(LONG_CYC) : 32'(SHORT_CYC);
        if (sst_r == S_STB_DN && factor)
            gap_load = 32'(gap_base * 32'(DOWN_FACTOR));
        else
            gap_load = gap_base;
    end

    always_comb begin
        sst_nxt    = sst_r;
        idx_nxt    = idx_r;
        strobe_nxt = 10'h000;
        en_nxt     = buck_rail_two_en_out & slot_ok;
        on_nxt     = seq_on_out;
        tmr_start  = 1'b0;
        case (sst_r)
            S_OFF: if (pwr_up_req_in) begin
                idx_nxt = STROBE_FIRST;
                sst_nxt = S_STB_UP;
            end
            S_STB_UP: begin
                strobe_nxt = 10'h001 << (idx_r - 4'h1);
                if (slot_ok && slot == idx_r)
                    en_nxt = 1'b1;
                if (idx_r == STROBE_LAST) begin
                    on_nxt  = 1'b1;
                    sst_nxt = S_ON;
                end else begin
                    tmr_start = 1'b1;
                    sst_nxt   = S_GAP_UP;
                end
            end
            S_GAP_UP: if (tmr_done) begin
                idx_nxt = idx_r + 4'h1;
                sst_nxt = S_STB_UP;
            end
            S_ON: if (pwr_dn_req_in) begin
                idx_nxt = STROBE_LAST;
                on_nxt  = 1'b0;
                sst_nxt = S_STB_DN;
            end
            S_STB_DN: begin
                strobe_nxt = 10'h001 << (idx_r - 4'h1);
                if (slot_ok && slot == idx_r)
                    en_nxt = 1'b0;
                if (idx_r == STROBE_FIRST) begin
                    sst_nxt = S_OFF;
                end else begin
                    tmr_start = 1'b1;
                    sst_nxt   = S_GAP_DN;
                end
            end
            S_GAP_DN: if (tmr_done) begin
                idx_nxt = idx_r - 4'h1;
                sst_nxt = S_STB_DN;
            end
            default: sst_nxt = S_OFF;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sst_r                <= S_OFF;
            idx_r                <= STROBE_FIRST;
            strobe_out           <= 10'h000;
            buck_rail_two_en_out <= 1'b0;
            buck_two_managed_out <= 1'b0;
            seq_on_out           <= 1'b0;
        end else if (ce_in) begin
            sst_r                <= sst_nxt;
            idx_r                <= idx_nxt;
            strobe_out           <= strobe_nxt;
            buck_rail_two_en_out <= en_nxt;
            buck_two_managed_out <= slot_ok;
            seq_on_out           <= on_nxt;
        end
    end

    pstc_gap_timer #(
        .CNT_W     (32)
    ) u_timer (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .ce_in     (ce_in),
        .start_in  (tmr_start),
        .load_in   (gap_load),
        .done_out  (tmr_done)
    );

    // Checks
    logic wrote_r;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            wrote_r <= 1'b0;
        else if (ce_in && wr_stb)
            wrote_r <= 1'b1;
    end

    sequence s_up_strobe;
        sst_r == S_STB_UP && ce_in && slot_ok && slot == idx_r;
    endsequence

    property p_slot_enable;
        @(posedge clk_in) disable iff (!resetn_in)
        s_up_strobe |=> buck_rail_two_en_out && strobe_out[slot - 4'h1];
    endproperty
    a_p_slot_enable: assert property (p_slot_enable)
        else $error("rail two not enabled at its strobe");

    property p_slot_off;
        @(posedge clk_in) disable iff (!resetn_in)
        !slot_ok && ce_in |=> !buck_rail_two_en_out && !buck_two_managed_out;
    endproperty
    a_p_slot_off: assert property (p_slot_off)
        else $error("unmanaged rail two was driven");

    property p_up_gap;
        @(posedge clk_in) disable iff (!resetn_in)
        sst_r == S_STB_UP && idx_r < 4'h9 |->
            gap_load == (gap_bits[idx_r - 4'h1] ? 32'(LONG_CYC)
                                               : 32'(SHORT_CYC));
    endproperty
    a_p_up_gap: assert property (p_up_gap)
        else $error("wrong power-up gap length");

    property p_gap_nine;
        @(posedge clk_in) disable iff (!resetn_in)
        sst_r == S_STB_UP && idx_r == 4'h9 |->
            gap_load == (regs_r.gap_high[0] ? 32'(LONG_CYC)
                                           : 32'(SHORT_CYC));
    endproperty
    a_p_gap_nine: assert property (p_gap_nine)
        else $error("wrong ninth gap length");

    property p_down_factor;
        @(posedge clk_in) disable iff (!resetn_in)
        sst_r == S_STB_DN && idx_r > 4'h1 && factor |->
            gap_load >= 32'(SHORT_CYC * DOWN_FACTOR);
    endproperty
    a_p_down_factor: assert property (p_down_factor)
        else $error("down gap not stretched");

    property p_up_unscaled;
        @(posedge clk_in) disable iff (!resetn_in)
        sst_r == S_STB_UP |-> gap_load <= 32'(LONG_CYC);
    endproperty
    a_p_up_unscaled: assert property (p_up_unscaled)
        else $error("power-up gap scaled");

    property p_reset_vals;
        @(posedge clk_in) disable iff (!resetn_in)
        !wrote_r |-> regs_r.slot == SLOT_RST && regs_r.gap_low == 8'h00
                     && regs_r.gap_high == 8'h00;
    endproperty
    a_p_reset_vals: assert property (p_reset_vals)
        else $error("register reset value wrong");

    property p_reserved;
        @(posedge clk_in) disable iff (!resetn_in)
        regs_r.gap_high[6:1] == 6'h00;
    endproperty
    a_p_reserved: assert property (p_reserved)
        else $error("reserved bits nonzero");

    property p_locked;
        @(posedge clk_in) disable iff (!resetn_in)
        wr_stb && ce_in && !unlock_r ##1 1'b1 |-> $stable(regs_r);
    endproperty
    a_p_locked: assert property (p_locked)
        else $error("locked register changed");

endmodule : pstc_seq_cfg

// file: hw/pstc_pkg.sv
package pstc_pkg;

    // Register offsets on the serial register port
    localparam logic [7:0] GAP_LOW_OFF   = 8'h20;
    localparam logic [7:0] GAP_HIGH_OFF  = 8'h21;
    localparam logic [7:0] SLOT_OFF      = 8'h22;
    localparam logic [7:0] UNLOCK_OFF    = 8'h10;
    localparam logic [7:0] UNLOCK_KEY    = 8'h7D;

    // Reset values
    localparam logic [7:0] GAP_LOW_RST   = 8'h00;
    localparam logic [7:0] GAP_HIGH_RST  = 8'h00;
    localparam logic [7:0] SLOT_RST      = 8'h98;

    // Field positions
    localparam int FACTOR_BIT   = 7;
    localparam int GAP9_BIT     = 0;
    localparam int SLOT_MSB     = 7;
    localparam int SLOT_LSB     = 4;

    // Slot codes that name a strobe
    localparam logic [3:0] SLOT_FIRST   = 4'h3;
    localparam logic [3:0] SLOT_LAST    = 4'hA;
    localparam logic [3:0] STROBE_FIRST = 4'h1;
    localparam logic [3:0] STROBE_LAST  = 4'hA;
    localparam int         STROBES      = 10;

    // Timing
    localparam int CLK_MHZ        = 200;
    localparam int GAP_SHORT_US   = 2000;
    localparam int GAP_LONG_US    = 5000;
    localparam int DOWN_FACTOR    = 10;
    localparam int GAP_SHORT_CYC  = GAP_SHORT_US * CLK_MHZ;
    localparam int GAP_LONG_CYC   = GAP_LONG_US * CLK_MHZ;

    // Serial port byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [6:0] {
        I_IDLE  = 7'h01,
        I_ADDR  = 7'h02,
        I_PTR   = 7'h04,
        I_WDATA = 7'h08,
        I_ACK_A = 7'h10,
        I_ACK_W = 7'h20,
        I_RACK  = 7'h40
    } pstc_i2c_st_t;

    typedef enum logic [5:0] {
        S_OFF    = 6'h01,
        S_STB_UP = 6'h02,
        S_GAP_UP = 6'h04,
        S_ON     = 6'h08,
        S_STB_DN = 6'h10,
        S_GAP_DN = 6'h20
    } pstc_seq_st_t;

    typedef struct packed {
        logic [7:0] gap_low;
        logic [7:0] gap_high;
        logic [7:0] slot;
    } pstc_regs_t;

endpackage : pstc_pkg

// file: hw/pstc_gap_timer.sv
`timescale 1ns/10ps
module pstc_gap_timer #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             ce_in,
    // Control
    input  wire logic             start_in,
    input  wire logic [CNT_W-1:0] load_in,
    output logic                  done_out
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             busy_r;
    logic             busy_nxt;
    logic             done_nxt;

    if (CNT_W < 2) begin : g_chk
        $error("pstc_gap_timer: CNT_W too small");
    end

    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (start_in) begin
            cnt_nxt  = load_in - CNT_W'(1);
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (cnt_r == '0) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r    <= '0;
            busy_r   <= 1'b0;
            done_out <= 1'b0;
        end else if (ce_in) begin
            cnt_r    <= cnt_nxt;
            busy_r   <= busy_nxt;
            done_out <= done_nxt;
        end
    end

endmodule : pstc_gap_timer

// file: tb/pstc_seq_cfg_bench.sv
`timescale 1ns/10ps
module pstc_seq_cfg_bench;
    import pstc_pkg::*;

    localparam int         SC = 20;
    localparam int         LC = 50;
    localparam logic [6:0] DA = 7'h5A;

    typedef struct {
        int         kind;
        int         idx;
        int         gap;
        logic       en;
        logic [7:0] dat;
    } pstc_note_t;

    logic       clk_in        = 1'b0;
    logic       resetn_in     = 1'b0;
    logic       scl_in        = 1'b1;
    logic       sda_m         = 1'b1;
    logic       pwr_up_req_in = 1'b0;
    logic       pwr_dn_req_in = 1'b0;
    logic       sda_in;
    logic       sda_out;
    logic       sda_oe_out;
    logic [9:0] strobe_out;
    logic       buck_rail_two_en_out;
    logic       buck_two_managed_out;
    logic       seq_on_out;
    logic [7:0] rd_byte;
    logic [7:0] g_lo;
    logic [7:0] g_hi;
    logic [7:0] slot;
    int         errors   = 0;
    int         compares = 0;
    int         cyc      = 0;
    int         last     = 0;
    event       rd_ev;
    pstc_note_t q[$];

    // Open-drain wire: the device only ever pulls low
    assign sda_in = sda_m & ~sda_oe_out;

    always #2.5 clk_in = ~clk_in;

    pstc_seq_cfg #(
        .DEV_ADDR  (DA),
        .SHORT_CYC (SC),
        .LONG_CYC  (LC)
    ) dut (
        .clk_in               (clk_in),
        .resetn_in            (resetn_in),
        .ce_in                (1'b1),
        .scl_in               (scl_in),
        .sda_in               (sda_in),
        .sda_out              (sda_out),
        .sda_oe_out           (sda_oe_out),
        .pwr_up_req_in        (pwr_up_req_in),
        .pwr_dn_req_in        (pwr_dn_req_in),
        .strobe_out           (strobe_out),
        .buck_rail_two_en_out (buck_rail_two_en_out),
        .buck_two_managed_out (buck_two_managed_out),
        .seq_on_out           (seq_on_out)
    );

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic tk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tk

    task automatic bit_w(input logic b);
        sda_m = b;
        tk(6);
        scl_in = 1'b1;
        tk(8);
        scl_in = 1'b0;
        tk(2);
    endtask : bit_w

    task automatic bit_r(output logic b);
        sda_m = 1'b1;
        tk(6);
        scl_in = 1'b1;
        tk(4);
        b = sda_in;
        tk(4);
        scl_in = 1'b0;
        tk(2);
    endtask : bit_r

    task automatic start_c;
        sda_m = 1'b1;
        tk(6);
        scl_in = 1'b1;
        tk(8);
        sda_m = 1'b0;
        tk(8);
        scl_in = 1'b0;
        tk(2);
    endtask : start_c

    task automatic stop_c;
        sda_m = 1'b0;
        tk(6);
        scl_in = 1'b1;
        tk(8);
        sda_m = 1'b1;
        tk(8);
    endtask : stop_c

    task automatic byte_w(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_w(d[i]);
        bit_r(a);
        check("ack", 1'b0, a);
    endtask : byte_w

    task automatic byte_r(output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_r(b);
            d[i] = b;
        end
        bit_w(1'b1);
    endtask : byte_r

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        start_c;
        byte_w({DA, 1'b0});
        byte_w(a);
        byte_w(d);
        stop_c;
    endtask : reg_wr

    // Unlock is one-shot, so every protected byte gets its own unlock
    task automatic prot_wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr(UNLOCK_OFF, UNLOCK_KEY);
        reg_wr(a, d);
    endtask : prot_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back('{0, 0, 0, 1'b0, e});
        start_c;
        byte_w({DA, 1'b0});
        byte_w(a);
        start_c;
        byte_w({DA, 1'b1});
        byte_r(rd_byte);
        stop_c;
        -> rd_ev;
    endtask : reg_rd

    // Notes every strobe of one sequence, then fires the request
    task automatic run(input logic up);
        logic [8:0] gv;
        logic       mg;
        int         f;
        int         k;
        int         t;
        gv = {g_hi[GAP9_BIT], g_lo};
        mg = slot[7:4] >= SLOT_FIRST && slot[7:4] <= SLOT_LAST;
        f  = (!up && g_hi[FACTOR_BIT]) ? DOWN_FACTOR : 1;
        for (int i = 1; i <= STROBES; i++) begin
            k = up ? i : STROBES + 1 - i;
            q.push_back('{1, k, (i == 1) ? 0 :
                (gv[up ? k - 2 : k - 1] ? LC : SC) * f + 2,
                mg && (up ? k >= slot[7:4] : k > slot[7:4]), 8'h00});
        end
        check("managed", mg, buck_two_managed_out);
        pwr_up_req_in = up;
        pwr_dn_req_in = !up;
        tk(1);
        pwr_up_req_in = 1'b0;
        pwr_dn_req_in = 1'b0;
        t = 0;
        while (q.size() > 0 && t < 20000) begin
            tk(1);
            t++;
        end
        tk(2);
        check("seq_on", up, seq_on_out);
        check("notes_left", 0, q.size());
    endtask : run

    // Result watcher: strobe pulses and finished reads
    always @(negedge clk_in) begin
        pstc_note_t n;
        cyc++;
        if (strobe_out !== 10'h000) begin
            n = q.pop_front();
            check("strobe", 10'h001 << (n.idx - 1), strobe_out);
            check("rail_two_en", n.en, buck_rail_two_en_out);
            if (n.gap > 0) check("gap", n.gap, cyc - last);
            last = cyc;
        end
    end

    always @(rd_ev) begin
        pstc_note_t r;
        r = q.pop_front();
        check("read", r.dat, rd_byte);
    end

    initial begin
        #500us;
        errors++;
        $display("Error watchdog expected done seen hang");
        conclude;
    end

    initial begin
        void'($urandom(32'h1BC5));
        repeat (2) @(posedge clk_in);
        #1;
        resetn_in = 1'b1;
        tk(2);
        reg_rd(GAP_LOW_OFF, GAP_LOW_RST);
        reg_rd(GAP_HIGH_OFF, GAP_HIGH_RST);
        reg_rd(SLOT_OFF, SLOT_RST);
        reg_rd(8'h30, 8'h00);
        $display("test reset_values done");
        reg_wr(GAP_LOW_OFF, 8'hFF);
        reg_rd(GAP_LOW_OFF, 8'h00);
        prot_wr(GAP_HIGH_OFF, 8'hFF);
        reg_rd(GAP_HIGH_OFF, 8'h81);
        $display("test lock_and_reserved done");
        for (int c = 0; c < 16; c++) begin
            prot_wr(SLOT_OFF, {c[3:0], 4'h8});
            tk(4);
            check("managed", c >= SLOT_FIRST && c <= SLOT_LAST, buck_two_managed_out);
        end
        $display("test slot_codes done");
        g_lo = 8'($urandom);
        g_hi = 8'h81;
        slot = {4'(SLOT_FIRST + $urandom % 8), 4'h8};
        prot_wr(GAP_LOW_OFF, g_lo);
        prot_wr(SLOT_OFF, slot);
        reg_rd(GAP_LOW_OFF, g_lo);
        run(1'b1);
        run(1'b0);
        $display("test factor_ten done");
        g_hi = 8'h00;
        slot = 8'hB8;
        prot_wr(GAP_HIGH_OFF, g_hi);
        prot_wr(SLOT_OFF, slot);
        run(1'b1);
        run(1'b0);
        $display("test factor_one done");
        conclude;
    end

endmodule : pstc_seq_cfg_bench
